/* File: rtl/bac_top.sv */
// boost converter digital control with measurement readout
//
// Summary of operation
// RULE_01 - readout bit five picks channel result shown
// RULE_02 - results averaged over a 134 ms window
// RULE_03 - host reads upper byte before lower byte
// RULE_04 - lower byte frozen from upper read onward
// RULE_05 - compensation bit four picks compensation channel
// RULE_06 - control bit three switches active output loader
// RULE_07 - control bit two: manual or adaptive voltage
// RULE_08 - control bit one: boost standby or active
// RULE_09 - enable starts 50 ms low-current phase first
// RULE_10 - manual code equals output volts, 5 to 20
// RULE_11 - codes below 5 or above 20 clamped
// RULE_12 - adaptive mode ignores written voltage code
// RULE_13 - adaptive keeps lowest driver voltage in window
// RULE_14 - adaptive output held within 5 to 20 V
// RULE_15 - adaptive control on after reset
// RULE_16 - stand-alone mode forces adaptive control
// RULE_17 - converter switches at 1 MHz
// RULE_18 - digital logic limits switch duty cycle
// RULE_19 - software should stop boost when unloaded
`timescale 1ns/1ps
`include "bac_defs.svh"

module bac_top import bac_pkg::*; #(
	parameter int SS_CYCLES = `BAC_SOFTSTART_CYCLES,
	parameter int AVG_CYCLES = `BAC_AVG_WINDOW_CYCLES,
	parameter int STEP_CYCLES = `BAC_ADAPT_STEP_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [`BAC_ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic [`BAC_ADC_W-1:0] TEMP_SENSOR_INPUT,
	input wire logic [`BAC_ADC_W-1:0] AUX_SENSOR_INPUT,
	input wire logic STANDALONE,
	input wire logic HEADROOM_LOW,
	input wire logic HEADROOM_HIGH,
	input wire logic LED_HIGH_CURRENT,
	input wire logic SW_CURRENT_TRIP,
	output logic HEADROOM_WIN_HIGH,
	output logic [`BAC_ADC_W-1:0] COMP_DATA,
	output logic DEVICE_ACTIVE,
	output bac_boost_type BOOST
);
	localparam int AW = `BAC_ADC_W;
	localparam int SSW = $clog2(SS_CYCLES + 1);
	localparam int STW = $clog2(STEP_CYCLES + 1);
	localparam int PER = `BAC_SW_PERIOD_CYCLES;
	localparam int MAX_ON = `BAC_SW_MAX_ON_CYCLES;
	localparam int MIN_ON = `BAC_SW_MIN_ON_CYCLES;
	localparam int PW = $clog2(PER);

	// sync bit order: standalone, low, high, high current, trip
	typedef struct packed {
		bac_ctrl_type ctrl;
		logic [7:0] vset;
		logic [7:0] lo_hold;
		logic [7:0] rdata;
		logic [AW-1:0] comp;
		bac_phase_type phase;
		logic [SSW-1:0] ss_cnt;
		logic [STW-1:0] step_cnt;
		logic [4:0] acode;
		logic [4:0] vcode;
		logic [PW-1:0] pwm_cnt;
		logic sw;
		logic [4:0] sync1;
		logic [4:0] sync2;
	} bac_top_state_type;

	bac_top_state_type st_reg;
	bac_top_state_type st_next;
	logic [AW-1:0] avg [2];
	logic [AW-1:0] res_sel;
	logic adaptive;
	logic run_req;
	logic [PW-1:0] cnt_next;
	logic sa_sync;
	logic hr_low;
	logic hr_high;
	logic trip;

	function automatic logic [4:0] bac_clamp(input logic [7:0] code);
		if (code < {3'h0, `BAC_VCODE_MIN}) begin
			bac_clamp = `BAC_VCODE_MIN;
		end else if (code > {3'h0, `BAC_VCODE_MAX}) begin
			bac_clamp = `BAC_VCODE_MAX;
		end else begin
			bac_clamp = code[4:0];
		end
	endfunction

	// one averager per channel; both run so switching readout is instant
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_avg
			bac_avg #(
				.W(AW),
				.LOG2(`BAC_AVG_LOG2),
				.TICK_CYCLES(AVG_CYCLES >> `BAC_AVG_LOG2)
			) bac_avg_i (
				.clk(REF_CLK),
				.reset(RESET),
				.ce(CE),
				.sample(gi == 0 ? TEMP_SENSOR_INPUT : AUX_SENSOR_INPUT),
				.avg(avg[gi])
			);
		end
	endgenerate

	assign sa_sync = st_reg.sync2[4];
	assign hr_low = st_reg.sync2[3];
	assign hr_high = st_reg.sync2[2];
	assign trip = st_reg.sync2[0];
	assign res_sel = st_reg.ctrl.readout_sel ? avg[1] : avg[0]; // [RULE_01]
	assign adaptive = st_reg.ctrl.vout_adaptive | sa_sync; // [RULE_07] [RULE_16]
	assign run_req = st_reg.ctrl.boost_on & st_reg.ctrl.dev_active; // [RULE_08]

	always_comb begin
		st_next = st_reg;
		st_next.sync1 = {STANDALONE, HEADROOM_LOW, HEADROOM_HIGH,
			LED_HIGH_CURRENT, SW_CURRENT_TRIP};
		st_next.sync2 = st_reg.sync1;

		if (REG_WR) begin
			case (REG_ADDR)
			`BAC_ADDR_VSET: begin
				st_next.vset = REG_WDATA;
			end
			`BAC_ADDR_CTRL: begin
				st_next.ctrl = bac_ctrl_type'(REG_WDATA & `BAC_CTRL_MASK);
			end
			default: begin
			end
			endcase
		end

		if (REG_RD) begin
			case (REG_ADDR)
			`BAC_ADDR_VSET: begin
				st_next.rdata = st_reg.vset;
			end
			`BAC_ADDR_CTRL: begin
				st_next.rdata = st_reg.ctrl;
			end
			`BAC_ADDR_RES_HI: begin
				st_next.rdata = {{(16 - AW){1'b0}}, res_sel[AW-1:8]}; // [RULE_01]
				// both bytes of a pair come from one averaged value
				st_next.lo_hold = res_sel[7:0]; // [RULE_04]
			end
			`BAC_ADDR_RES_LO: begin
				st_next.rdata = st_reg.lo_hold; // [RULE_04]
			end
			default: begin
				st_next.rdata = 8'h00;
			end
			endcase
		end

		st_next.comp = st_reg.ctrl.comp_sel ? avg[1] : avg[0]; // [RULE_05]

		case (st_reg.phase)
		BAC_OFF: begin
			st_next.ss_cnt = '0;
			if (run_req) begin
				st_next.phase = BAC_SOFT; // [RULE_09]
			end
		end
		BAC_SOFT: begin
			if (!run_req) begin
				st_next.phase = BAC_OFF;
			end else if (st_reg.ss_cnt == SSW'(SS_CYCLES - 1)) begin
				st_next.phase = BAC_RUN; // [RULE_09]
			end else begin
				st_next.ss_cnt = st_reg.ss_cnt + 1'b1;
			end
		end
		BAC_RUN: begin
			if (!run_req) begin
				st_next.phase = BAC_OFF; // [RULE_08]
			end
		end
		default: begin
			st_next.phase = BAC_OFF;
		end
		endcase

		// slow steps let the analog loop settle between code changes
		if (st_reg.step_cnt == STW'(STEP_CYCLES - 1)) begin
			st_next.step_cnt = '0;
		end else begin
			st_next.step_cnt = st_reg.step_cnt + 1'b1;
		end
		if (!adaptive) begin
			// adaptive starts from the manual value, avoiding a jump
			st_next.acode = bac_clamp(st_reg.vset);
		end else if (st_reg.phase == BAC_RUN && st_next.step_cnt == '0) begin
			if (hr_low && st_reg.acode < `BAC_VCODE_MAX) begin
				st_next.acode = st_reg.acode + 1'b1; // [RULE_13] [RULE_14]
			end else if (hr_high && !hr_low &&
				st_reg.acode > `BAC_VCODE_MIN) begin
				st_next.acode = st_reg.acode - 1'b1; // [RULE_13] [RULE_14]
			end
		end
		st_next.vcode = adaptive ? st_reg.acode : // [RULE_12]
			bac_clamp(st_reg.vset); // [RULE_10] [RULE_11]

		cnt_next = (st_reg.pwm_cnt == PW'(PER - 1)) ? '0 :
			st_reg.pwm_cnt + 1'b1; // [RULE_17]
		// gate drops with the request so standby never sees a stray pulse
		if (st_reg.phase == BAC_OFF || !run_req) begin
			st_next.pwm_cnt = '0;
			st_next.sw = 1'b0;
		end else begin
			st_next.pwm_cnt = cnt_next;
			if (cnt_next == '0) begin
				// without the loader a pulse is skipped while the current trip is set
				st_next.sw = st_reg.ctrl.loader_on | !trip; // [RULE_06]
			end else begin
				st_next.sw = st_reg.sw && cnt_next < PW'(MAX_ON) && // [RULE_18]
					!(trip && cnt_next >= PW'(MIN_ON));
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			st_reg <= '0;
			st_reg.ctrl <= bac_ctrl_type'(`BAC_CTRL_RESET); // [RULE_15]
			st_reg.vset <= `BAC_VSET_RESET;
			st_reg.phase <= BAC_OFF;
			st_reg.acode <= `BAC_VCODE_MIN;
			st_reg.vcode <= `BAC_VCODE_MIN;
		end else if (CE) begin
			st_reg <= st_next;
		end
	end

	assign REG_RDATA = st_reg.rdata;
	assign COMP_DATA = st_reg.comp;
	assign DEVICE_ACTIVE = st_reg.ctrl.dev_active;
	assign HEADROOM_WIN_HIGH = st_reg.sync2[1]; // [RULE_13]
	assign BOOST = '{sw: st_reg.sw,
		boost_en: st_reg.phase != BAC_OFF,
		softstart: st_reg.phase == BAC_SOFT, // [RULE_09]
		loader_en: st_reg.ctrl.loader_on && st_reg.phase != BAC_OFF, // [RULE_06]
		vcode: st_reg.vcode};

	a_readout_hi: assert property ( // [RULE_01]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		REG_RD && REG_ADDR == `BAC_ADDR_RES_HI
		|=> REG_RDATA[AW-9:0] == $past(res_sel[AW-1:8]))
		else $error("upper byte not from selected channel");

	a_lower_pair: assert property ( // [RULE_04]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		(REG_RD && REG_ADDR == `BAC_ADDR_RES_HI) ##1
		(REG_RD && REG_ADDR == `BAC_ADDR_RES_LO)
		|=> REG_RDATA == $past(res_sel[7:0], 2))
		else $error("lower byte not from same result");

	a_comp_select: assert property ( // [RULE_05]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		##1 COMP_DATA == ($past(st_reg.ctrl.comp_sel) ?
		$past(avg[1]) : $past(avg[0])))
		else $error("compensation channel wrong");

	a_loader_ctrl: assert property ( // [RULE_06]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		!st_reg.ctrl.loader_on |-> !BOOST.loader_en)
		else $error("loader on while disabled");

	a_manual_clamp: assert property ( // [RULE_10]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		!adaptive ##1 !adaptive
		|-> BOOST.vcode == bac_clamp($past(st_reg.vset)))
		else $error("manual code not clamped value");

	a_vcode_range: assert property ( // [RULE_11] [RULE_14]
		@(posedge REF_CLK) disable iff (RESET)
		BOOST.vcode >= `BAC_VCODE_MIN && BOOST.vcode <= `BAC_VCODE_MAX)
		else $error("voltage code out of range");

	a_boost_standby: assert property ( // [RULE_08]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		!st_reg.ctrl.boost_on |=> !BOOST.boost_en && !BOOST.sw)
		else $error("boost running in standby");

	a_soft_length: assert property ( // [RULE_09]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		$rose(st_reg.phase == BAC_RUN)
		|-> $past(st_reg.ss_cnt) == SSW'(SS_CYCLES - 1))
		else $error("soft start length wrong");

	a_standalone: assert property ( // [RULE_16]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		sa_sync |=> BOOST.vcode == $past(st_reg.acode))
		else $error("stand-alone not adaptive");

	a_sw_period: assert property ( // [RULE_17]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		$rose(st_reg.sw) |-> st_reg.pwm_cnt == '0)
		else $error("switch pulse off period start");

	a_duty_limit: assert property ( // [RULE_18]
		@(posedge REF_CLK) disable iff (RESET || !CE)
		st_reg.pwm_cnt >= PW'(MAX_ON) |-> !st_reg.sw)
		else $error("duty cycle limit exceeded");

	c_soft_done: cover property (@(posedge REF_CLK) disable iff (RESET)
		$rose(st_reg.phase == BAC_RUN));
	c_read_pair: cover property (@(posedge REF_CLK) disable iff (RESET)
		(REG_RD && REG_ADDR == `BAC_ADDR_RES_HI) ##1
		(REG_RD && REG_ADDR == `BAC_ADDR_RES_LO));
	c_adapt_up: cover property (@(posedge REF_CLK) disable iff (RESET)
		adaptive && st_next.acode > st_reg.acode);
	c_sw_pulse: cover property (@(posedge REF_CLK) disable iff (RESET)
		$fell(st_reg.sw));

endmodule

/* File: rtl/bac_defs.svh */
// addresses, reset values, limits and timing figures of the boost control
`ifndef BAC_DEFS_SVH
`define BAC_DEFS_SVH

`define BAC_ADDR_W 7
`define BAC_ADDR_VSET 7'h05
`define BAC_ADDR_CTRL 7'h06
`define BAC_ADDR_RES_HI 7'h07
`define BAC_ADDR_RES_LO 7'h08

`define BAC_CTRL_RESET 8'h04
`define BAC_CTRL_MASK 8'h3f
`define BAC_VSET_RESET 8'h05

`define BAC_VCODE_MIN 5'h05
`define BAC_VCODE_MAX 5'h14

`define BAC_ADC_W 12
`define BAC_AVG_LOG2 4

`define BAC_CLK_KHZ 25000
`define BAC_CLK_PERIOD_NS 40
`define BAC_SOFTSTART_MS 50
`define BAC_AVG_WINDOW_MS 134
`define BAC_ADAPT_STEP_US 1000
`define BAC_SW_FREQ_KHZ 1000
`define BAC_SW_MAX_DUTY_PCT 88
`define BAC_SW_MIN_PULSE_NS 50

`define BAC_SOFTSTART_CYCLES (`BAC_SOFTSTART_MS * `BAC_CLK_KHZ)
`define BAC_AVG_WINDOW_CYCLES (`BAC_AVG_WINDOW_MS * `BAC_CLK_KHZ)
`define BAC_ADAPT_STEP_CYCLES (`BAC_ADAPT_STEP_US * `BAC_CLK_KHZ / 1000)
`define BAC_SW_PERIOD_CYCLES (`BAC_CLK_KHZ / `BAC_SW_FREQ_KHZ)
`define BAC_SW_MAX_ON_CYCLES \
	(`BAC_SW_PERIOD_CYCLES * `BAC_SW_MAX_DUTY_PCT / 100)
`define BAC_SW_MIN_ON_CYCLES \
	((`BAC_SW_MIN_PULSE_NS + `BAC_CLK_PERIOD_NS - 1) / `BAC_CLK_PERIOD_NS)

`endif

/* File: rtl/bac_pkg.sv */
// types shared by the boost and measurement control
package bac_pkg;

	typedef struct packed {
		logic [1:0] rsvd;
		logic readout_sel;
		logic comp_sel;
		logic loader_on;
		logic vout_adaptive;
		logic boost_on;
		logic dev_active;
	} bac_ctrl_type;

	typedef enum logic [1:0] {
		BAC_OFF,
		BAC_SOFT,
		BAC_RUN
	} bac_phase_type;

	typedef struct packed {
		logic sw;
		logic boost_en;
		logic softstart;
		logic loader_en;
		logic [4:0] vcode;
	} bac_boost_type;

endpackage

/* File: rtl/bac_avg.sv */
// block averager: mean of 2**LOG2 evenly spaced samples per window
`timescale 1ns/1ps
`include "bac_defs.svh"

module bac_avg import bac_pkg::*; #(
	parameter int W = `BAC_ADC_W,
	parameter int LOG2 = `BAC_AVG_LOG2,
	parameter int TICK_CYCLES = `BAC_AVG_WINDOW_CYCLES >> `BAC_AVG_LOG2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [W-1:0] sample,
	output logic [W-1:0] avg
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [TW-1:0] tick_cnt;
		logic [LOG2-1:0] n;
		logic [W+LOG2-1:0] sum;
		logic [W-1:0] avg;
	} bac_avg_state_type;

	bac_avg_state_type st_reg;
	bac_avg_state_type st_next;
	logic [W+LOG2-1:0] sum_add;

	always_comb begin
		st_next = st_reg;
		sum_add = st_reg.sum + {{LOG2{1'b0}}, sample};
		if (st_reg.tick_cnt == TW'(TICK_CYCLES - 1)) begin
			st_next.tick_cnt = '0;
			st_next.n = st_reg.n + 1'b1;
			// a full window replaces the result at once, never partly
			if (st_reg.n == {LOG2{1'b1}}) begin
				st_next.avg = sum_add[W+LOG2-1:LOG2]; // [RULE_02]
				st_next.sum = '0;
			end else begin
				st_next.sum = sum_add; // [RULE_02]
			end
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign avg = st_reg.avg;

	a_avg_window: assert property ( // [RULE_02]
		@(posedge clk) disable iff (reset || !ce)
		!(st_reg.tick_cnt == TW'(TICK_CYCLES - 1) && st_reg.n == {LOG2{1'b1}})
		|=> $stable(avg))
		else $error("average changed outside window end");

endmodule

/* File: tb/boost_and_adc_control_tb.sv */
// self-checking bench for the boost and measurement control block
`timescale 1ns/1ps
`include "bac_defs.svh"

module boost_and_adc_control_tb import bac_pkg::*; ;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [11:0] temp_in = 12'h000;
	logic [11:0] aux_in = 12'h000;
	logic standalone = 1'b0;
	logic hr_low = 1'b0;
	logic hr_high = 1'b0;
	logic led_hi = 1'b0;
	logic sw_trip = 1'b0;
	logic win_high;
	logic [11:0] comp_data;
	logic dev_active;
	bac_boost_type boost;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int rises;
	int hi_len;
	int max_hi;
	logic sw_last;
	logic [7:0] vin [7] = '{8'h00, 8'h04, 8'h05, 8'h0c, 8'h14, 8'h15, 8'h1f};
	logic [4:0] vexp [7] = '{5'h05, 5'h05, 5'h05, 5'h0c, 5'h14, 5'h14, 5'h14};

	bac_top #(
		.SS_CYCLES(50),
		.AVG_CYCLES(160),
		.STEP_CYCLES(8)
	) bac_top_i (
		.REF_CLK(ref_clk),
		.RESET(reset),
		.CE(ce),
		.REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata),
		.REG_WR(reg_wr),
		.REG_RD(reg_rd),
		.REG_RDATA(reg_rdata),
		.TEMP_SENSOR_INPUT(temp_in),
		.AUX_SENSOR_INPUT(aux_in),
		.STANDALONE(standalone),
		.HEADROOM_LOW(hr_low),
		.HEADROOM_HIGH(hr_high),
		.LED_HIGH_CURRENT(led_hi),
		.SW_CURRENT_TRIP(sw_trip),
		.HEADROOM_WIN_HIGH(win_high),
		.COMP_DATA(comp_data),
		.DEVICE_ACTIVE(dev_active),
		.BOOST(boost)
	);

	always #20 ref_clk = ~ref_clk;

	task automatic close_out();
		$display("checks %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// limit sized well above the few thousand cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			failures = failures + 1;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask

	// data is registered at the taking edge; sampled a cycle later
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		chk("rdata", reg_rdata, exp);
	endtask

	// back-to-back pair: lower address presented right after the upper
	task automatic rd_pair(input logic [7:0] hi, input logic [7:0] lo);
		reg_addr = `BAC_ADDR_RES_HI;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		chk("rdata_hi", reg_rdata, hi);
		reg_addr = `BAC_ADDR_RES_LO;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		chk("rdata_lo", reg_rdata, lo);
		@(negedge ref_clk);
	endtask

	// count gate rising edges and widest pulse over n cycles
	task automatic measure(input int n);
		rises = 0;
		hi_len = 0;
		max_hi = 0;
		sw_last = boost.sw;
		repeat (n) begin
			@(negedge ref_clk);
			if (boost.sw === 1'b1 && sw_last === 1'b0) rises++;
			hi_len = (boost.sw === 1'b1) ? hi_len + 1 : 0;
			if (hi_len > max_hi) max_hi = hi_len;
			sw_last = boost.sw;
		end
	endtask

	initial begin
		idle(10);
		reset = 1'b0;
		idle(1);
		chk("comp_data", comp_data, 16'h0000);
		chk("boost", boost, 16'h0005);
		rdc(`BAC_ADDR_CTRL, 8'h04);
		rdc(`BAC_ADDR_VSET, 8'h05);
		rdc(7'h10, 8'h00);
		wr(`BAC_ADDR_CTRL, 8'hff);
		rdc(`BAC_ADDR_CTRL, 8'h3f);
		wr(`BAC_ADDR_CTRL, 8'h01);
		idle(3);
		chk("active", dev_active, 16'h0001);
		chk("boost_en", boost.boost_en, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(`BAC_ADDR_VSET, vin[i]);
			idle(4);
			chk("vcode", boost.vcode, vexp[i]);
		end
		wr(`BAC_ADDR_CTRL, 8'h03);
		idle(5);
		chk("soft", {boost.boost_en, boost.softstart}, 16'h0003);
		idle(60);
		chk("run", {boost.boost_en, boost.softstart}, 16'h0002);
		// ten switching periods
		measure(250);
		chk("sw_rises", rises, 16'd10);
		chk("duty_ok", max_hi <= 22 && max_hi > 0, 16'h0001);
		wr(`BAC_ADDR_CTRL, 8'h0b);
		idle(3);
		chk("loader", boost.loader_en, 16'h0001);
		wr(`BAC_ADDR_CTRL, 8'h03);
		idle(3);
		chk("loader", boost.loader_en, 16'h0000);
		wr(`BAC_ADDR_CTRL, 8'h09);
		idle(3);
		chk("standby", {boost.boost_en, boost.loader_en}, 16'h0000);
		wr(`BAC_ADDR_VSET, 8'h0c);
		idle(1);
		wr(`BAC_ADDR_CTRL, 8'h07);
		idle(1);
		wr(`BAC_ADDR_VSET, 8'h03);
		idle(100);
		chk("vcode", boost.vcode, 16'h000c);
		hr_low = 1'b1;
		idle(200);
		chk("vcode", boost.vcode, 16'h0014);
		hr_low = 1'b0;
		hr_high = 1'b1;
		idle(200);
		chk("vcode", boost.vcode, 16'h0005);
		hr_high = 1'b0;
		wr(`BAC_ADDR_CTRL, 8'h03);
		standalone = 1'b1;
		hr_low = 1'b1;
		idle(200);
		chk("vcode", boost.vcode, 16'h0014);
		standalone = 1'b0;
		hr_low = 1'b0;
		idle(10);
		chk("vcode", boost.vcode, 16'h0005);
		led_hi = 1'b1;
		idle(4);
		chk("win_high", win_high, 16'h0001);
		led_hi = 1'b0;
		idle(4);
		chk("win_high", win_high, 16'h0000);
		temp_in = 12'habc;
		aux_in = 12'h123;
		wr(`BAC_ADDR_CTRL, 8'h01);
		idle(2);
		chk("comp_data", comp_data, 16'h0000);
		idle(360);
		chk("comp_data", comp_data, 16'h0abc);
		rdc(`BAC_ADDR_RES_HI, 8'h0a);
		rdc(`BAC_ADDR_RES_LO, 8'hbc);
		wr(`BAC_ADDR_CTRL, 8'h31);
		idle(4);
		chk("comp_data", comp_data, 16'h0123);
		rdc(`BAC_ADDR_RES_HI, 8'h01);
		rdc(`BAC_ADDR_RES_LO, 8'h23);
		wr(`BAC_ADDR_CTRL, 8'h01);
		rdc(`BAC_ADDR_RES_HI, 8'h0a);
		// new data must not leak into the half already latched
		temp_in = 12'h456;
		idle(360);
		chk("comp_data", comp_data, 16'h0456);
		rdc(`BAC_ADDR_RES_LO, 8'hbc);
		rdc(`BAC_ADDR_RES_HI, 8'h04);
		rdc(`BAC_ADDR_RES_LO, 8'h56);
		rd_pair(8'h04, 8'h56);
		// current trip: skipped pulses without loader, short pulses with it
		sw_trip = 1'b1;
		wr(`BAC_ADDR_CTRL, 8'h03);
		idle(80);
		measure(100);
		chk("trip_skip", rises, 16'd0);
		wr(`BAC_ADDR_CTRL, 8'h0b);
		measure(100);
		chk("trip_pulse", max_hi, 16'd2);
		sw_trip = 1'b0;
		close_out();
	end
endmodule
